// File: rlt_cfg.svh
`ifndef RLT_CFG_SVH
`define RLT_CFG_SVH

// word indices; byte address is four times the index
`define RLT_CTL_IDX_BASE  10'h080
`define RLT_IDX_STRIDE    3
`define RLT_DATL_OFS      1
`define RLT_DATH_OFS      2
`define RLT_CFG_IDX_BASE  10'h0a0

// control register fields
`define RLT_CTL_RUN       0
`define RLT_CTL_RESTART   1
`define RLT_CTL_DIV_LO    2
`define RLT_CTL_DIV_HI    3
`define RLT_CTL_REPEAT    4
`define RLT_CTL_IE        6
`define RLT_CTL_DONE      7
`define RLT_CTL_RESET     8'h00

// source and output configuration fields
`define RLT_CFG_SRC_LO    0
`define RLT_CFG_SRC_HI    1
`define RLT_CFG_TOG       2
`define RLT_CFG_RESET     8'h00

// prescaler terminal counts (ratio minus one)
`define RLT_DIV4_LAST     8'h03
`define RLT_DIV16_LAST    8'h0f
`define RLT_DIV64_LAST    8'h3f
`define RLT_DIV256_LAST   8'hff

// timer family layout and input latencies in system clock edges
`define RLT_NUM_TIMERS    6
`define RLT_SRC_TIMERS    4
`define RLT_FIRST_OUT     4
`define RLT_EVT_LATENCY   5

`endif

// File: rlt_pin_model.sv
`timescale 1ns/1ps
// far side: port event pins and slow oscillator, one edge per request
module rlt_pin_model (
    input  wire logic       sys_clk,      // system clock
    input  wire logic       reset,        // synchronous reset
    input  wire logic [2:0] go,           // request: pin a rise, pin b rise, osc fall
    output logic            event_pin_a,  // event pin a
    output logic            event_pin_b,  // event pin b
    output logic            slow_osc_out  // oscillator, idles high
);
    logic [1:0] busy [3];
    // each event holds three cycles and ignores requests meanwhile,
    // so the rate never exceeds half the system clock
    always_ff @(posedge sys_clk) begin
        for (int k = 0; k < 3; k++) begin
            if (reset) begin
                busy[k] <= 2'h0;
            end
            else if (busy[k] != 2'h0) begin
                busy[k] <= busy[k] - 2'h1;
            end
            else if (go[k]) begin
                busy[k] <= 2'h3;
            end
        end
    end
    // pins are always driven, so no stale value hides behind a release
    assign event_pin_a  = (busy[0] != 2'h0);
    assign event_pin_b  = (busy[1] != 2'h0);
    assign slow_osc_out = (busy[2] == 2'h0);
endmodule

// File: rlt_pkg.sv
package rlt_pkg;
    // count source selection
    typedef enum logic [1:0] {
        RLT_SRC_SYS,
        RLT_SRC_PIN,
        RLT_SRC_RTC,
        RLT_SRC_NONE
    } rlt_src_t;

    // prescaler divide codes
    typedef enum logic [1:0] {
        RLT_DIV_4,
        RLT_DIV_16,
        RLT_DIV_64,
        RLT_DIV_256
    } rlt_div_t;
endpackage

// File: rlt_timer.sv
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "rlt_cfg.svh"
// Summary of operation
// - reload one gives one prescaled tick time-out
// - reload zero wraps, giving 65536 ticks
// - time-out equals divide ratio times reload
// - single-pass end stops and clears run bit
// - continuous end reloads from reload registers
// - continuous mode repeats until run bit cleared
// - low-byte read latches high byte coherently
// - done flag set on step one to zero
// - loading zero never sets done flag
// - interrupt enable gates done flag to request
// - control read clears flag and request
// - control bits run, restart, repeat, enable, divider
// - timers 0-3 select clock, pin or slow oscillator
// - slow oscillator fall counts at second edge
// - pin events bypass prescaler, one per rise
// - pin rise updates counter at fifth edge
// - timers 4-5 toggle output at each end
// - toggle output off after reset
// - continuous toggle period is twice time-out
// - writing restart bit reloads and restarts
// - divider codes select 4, 16, 64, 256
// - reload writes share addresses with count reads
module rlt_timer #(
    parameter int TIMER_INDEX = 0,                // 0..5, picks addresses and features
    parameter int EVT_LATENCY = `RLT_EVT_LATENCY  // pin edge to counter update, in edges
) (
    input  wire logic        sys_clk,        // system clock, 100 MHz
    input  wire logic        reset,          // synchronous reset, active high
    input  wire logic        hsel,           // ahb slave select
    input  wire logic [31:0] haddr,          // ahb address
    input  wire logic [1:0]  htrans,         // ahb transfer type
    input  wire logic        hwrite,         // ahb write
    input  wire logic [2:0]  hsize,          // ahb size, word only
    input  wire logic        hready,         // ahb bus ready
    input  wire logic [31:0] hwdata,         // ahb write data
    output logic             hreadyout,      // always ready
    output logic             hresp,          // always okay
    output logic [31:0]      hrdata,         // ahb read data, registered
    input  wire logic        event_pin_a,    // event input for timers 0 and 2
    input  wire logic        event_pin_b,    // event input for timers 1 and 3
    input  wire logic        slow_osc_out,   // real-time oscillator output
    output logic             toggle_out_a,   // timer 4 toggle output
    output logic             toggle_out_a_oe,// timer 4 toggle drive enable
    output logic             toggle_out_b,   // timer 5 toggle output
    output logic             toggle_out_b_oe,// timer 5 toggle drive enable
    output logic             count_done_irq  // interrupt request, active high
);
    import rlt_pkg::*;

    // refuse settings the logic cannot serve
    if (TIMER_INDEX < 0 || TIMER_INDEX >= `RLT_NUM_TIMERS) begin : g_bad_index
        $error("timer index out of range");
    end
    if (EVT_LATENCY < 2) begin : g_bad_latency
        $error("event latency must be at least two edges");
    end

    localparam logic [9:0] CTL_IDX  = 10'(`RLT_CTL_IDX_BASE + `RLT_IDX_STRIDE * TIMER_INDEX);
    localparam logic [9:0] DATL_IDX = 10'(CTL_IDX + `RLT_DATL_OFS);
    localparam logic [9:0] DATH_IDX = 10'(CTL_IDX + `RLT_DATH_OFS);
    localparam logic [9:0] CFG_IDX  = 10'(`RLT_CFG_IDX_BASE + TIMER_INDEX);
    localparam bit         HAS_SRC  = TIMER_INDEX < `RLT_SRC_TIMERS;
    localparam bit         HAS_OUT  = TIMER_INDEX >= `RLT_FIRST_OUT;

    logic             wr_pend_reg;    // write data phase pending
    logic [9:0]       wr_idx_reg;     // word index of pending write
    logic [31:0]      hrdata_reg;     // read data for the data phase
    logic             run_reg;        // timer_run_bit
    logic             restart_reg;    // reload-and-restart enable
    rlt_div_t         div_reg;        // prescaler code
    logic             repeat_reg;     // repeat_select
    logic             ie_reg;         // interrupt enable
    logic             done_reg;       // count_done_flag
    rlt_src_t         src_reg;        // count source
    logic             tog_en_reg;     // toggle output enable
    logic [15:0]      reload_reg;     // reload_high_reg and reload_low_reg
    logic [15:0]      count_reg;      // down-counter
    logic [7:0]       high_latch_reg; // count_high_reg snapshot
    logic [7:0]       prescale_reg;   // prescaler
    logic [7:0]       prescale_last;  // prescaler terminal count
    logic [EVT_LATENCY-1:0] evt_pipe_reg; // event pin sampling pipeline
    logic             osc_q1_reg;     // oscillator sample
    logic             osc_q2_reg;     // oscillator sample, one edge older
    logic             toggle_reg;     // toggle output level
    logic             addr_take;
    logic             rd_take;
    logic [9:0]       rd_idx;
    logic             ctl_rd;
    logic             datl_rd;
    logic [7:0]       wr_data;
    logic             wr_ctl;
    logic             do_restart;
    logic             sel_pin;
    logic             pre_tick;
    logic             evt_tick;
    logic             rtc_tick;
    logic             cnt_tick;
    logic             eoc;
    logic [7:0]       ctl_value;

    // ahb address phase decode; single zero-wait slave
    assign addr_take = hsel && hready && htrans[1];
    assign rd_take   = addr_take && !hwrite;
    assign rd_idx    = haddr[11:2];
    assign ctl_rd    = rd_take && rd_idx == CTL_IDX;
    assign datl_rd   = rd_take && rd_idx == DATL_IDX;
    assign wr_data   = hwdata[7:0];
    assign wr_ctl    = wr_pend_reg && wr_idx_reg == CTL_IDX;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    // remember the write so hwdata can be taken in its data phase
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 10'h000;
        end else begin
            wr_pend_reg <= addr_take && hwrite;
            if (addr_take) begin
                wr_idx_reg <= rd_idx;
            end
        end
    end

    // control byte as software sees it; bit 5 reads zero
    assign ctl_value = {done_reg, ie_reg, 1'b0, repeat_reg, div_reg, restart_reg, run_reg};

    // read data is captured at the address edge, so side effects land there too
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            if (rd_idx == CTL_IDX) begin
                hrdata_reg <= {24'h00_0000, ctl_value};
            end else if (rd_idx == DATL_IDX) begin
                hrdata_reg <= {24'h00_0000, count_reg[7:0]};
            end else if (rd_idx == DATH_IDX) begin
                hrdata_reg <= {24'h00_0000, high_latch_reg};
            end else if (rd_idx == CFG_IDX) begin
                hrdata_reg <= {29'h0000_0000, tog_en_reg, src_reg};
            end else begin
                hrdata_reg <= 32'h0000_0000;
            end
        end else begin
            hrdata_reg <= 32'h0000_0000;
        end
    end

    // high byte frozen on low-byte read; count keeps running
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            high_latch_reg <= 8'h00;
        end else if (datl_rd) begin
            high_latch_reg <= count_reg[15:8];
        end
    end

    // control fields; a software write beats the single-pass self clear
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            run_reg     <= 1'b0;
            restart_reg <= 1'b0;
            div_reg     <= RLT_DIV_4;
            repeat_reg  <= 1'b0;
            ie_reg      <= 1'b0;
        end else if (wr_ctl) begin
            run_reg     <= wr_data[`RLT_CTL_RUN];
            restart_reg <= wr_data[`RLT_CTL_RESTART];
            div_reg     <= rlt_div_t'(wr_data[`RLT_CTL_DIV_HI:`RLT_CTL_DIV_LO]);
            repeat_reg  <= wr_data[`RLT_CTL_REPEAT];
            ie_reg      <= wr_data[`RLT_CTL_IE];
        end else if (eoc && !repeat_reg) begin
            run_reg     <= 1'b0;
        end
    end

    // source and toggle configuration; fixed for timers without the feature
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            src_reg    <= RLT_SRC_SYS;
            tog_en_reg <= 1'b0;
        end else if (wr_pend_reg && wr_idx_reg == CFG_IDX) begin
            if (HAS_SRC) begin
                src_reg <= rlt_src_t'(wr_data[`RLT_CFG_SRC_HI:`RLT_CFG_SRC_LO]);
            end
            tog_en_reg <= HAS_OUT && wr_data[`RLT_CFG_TOG];
        end
    end

    // reload bytes sit behind the count read addresses
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reload_reg <= 16'h0000;
        end else if (wr_pend_reg && wr_idx_reg == DATL_IDX) begin
            reload_reg[7:0] <= wr_data;
        end else if (wr_pend_reg && wr_idx_reg == DATH_IDX) begin
            reload_reg[15:8] <= wr_data;
        end
    end

    // divide code to terminal count
    always_comb begin
        unique case (div_reg)
            RLT_DIV_4:   prescale_last = `RLT_DIV4_LAST;
            RLT_DIV_16:  prescale_last = `RLT_DIV16_LAST;
            RLT_DIV_64:  prescale_last = `RLT_DIV64_LAST;
            RLT_DIV_256: prescale_last = `RLT_DIV256_LAST;
        endcase
    end

    assign do_restart = wr_ctl && wr_data[`RLT_CTL_RESTART];
    assign pre_tick   = prescale_reg == prescale_last;

    // prescaler restarts with the timer so the first period is full length
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prescale_reg <= 8'h00;
        end else if (!run_reg || do_restart || pre_tick) begin
            prescale_reg <= 8'h00;
        end else begin
            prescale_reg <= prescale_reg + 8'h01;
        end
    end

    // pin and oscillator sampling; pins are already synchronous
    assign sel_pin = (TIMER_INDEX % 2 == 0) ? event_pin_a : event_pin_b;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            evt_pipe_reg <= '0;
            osc_q1_reg   <= 1'b0;
            osc_q2_reg   <= 1'b0;
        end else begin
            evt_pipe_reg <= {evt_pipe_reg[EVT_LATENCY-2:0], sel_pin};
            osc_q1_reg   <= slow_osc_out;
            osc_q2_reg   <= osc_q1_reg;
        end
    end

    // event rate above half the clock merges edges in this pipeline
    assign evt_tick = evt_pipe_reg[EVT_LATENCY-2] && !evt_pipe_reg[EVT_LATENCY-1];
    assign rtc_tick = osc_q2_reg && !osc_q1_reg;

    // tick source select; pin and oscillator bypass the prescaler
    always_comb begin
        unique case (src_reg)
            RLT_SRC_SYS:  cnt_tick = run_reg && pre_tick;
            RLT_SRC_PIN:  cnt_tick = run_reg && evt_tick;
            RLT_SRC_RTC:  cnt_tick = run_reg && rtc_tick;
            RLT_SRC_NONE: cnt_tick = 1'b0;
        endcase
    end

    // end of count only on the step from one to zero
    assign eoc = cnt_tick && count_reg == 16'h0001;

    // down-counter
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_reg <= 16'h0000;
        end else if (do_restart) begin
            count_reg <= reload_reg;
        end else if (cnt_tick) begin
            if (eoc && repeat_reg) begin
                count_reg <= reload_reg;
            end else begin
                count_reg <= count_reg - 16'h0001;
            end
        end
    end

    // sticky done flag; a new end beats a simultaneous control read
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            done_reg <= 1'b0;
        end else if (eoc) begin
            done_reg <= 1'b1;
        end else if (ctl_rd) begin
            done_reg <= 1'b0;
        end
    end

    assign count_done_irq = done_reg && ie_reg;

    // toggle output flips once per end, so its period is two time-outs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            toggle_reg <= 1'b0;
        end else if (HAS_OUT && tog_en_reg && eoc) begin
            toggle_reg <= !toggle_reg;
        end
    end

    assign toggle_out_a    = (TIMER_INDEX == `RLT_FIRST_OUT) && toggle_reg;
    assign toggle_out_a_oe = (TIMER_INDEX == `RLT_FIRST_OUT) && tog_en_reg;
    assign toggle_out_b    = (TIMER_INDEX == `RLT_FIRST_OUT + 1) && toggle_reg;
    assign toggle_out_b_oe = (TIMER_INDEX == `RLT_FIRST_OUT + 1) && tog_en_reg;

    // checks on counting, flag and input timing
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    single_pass_stop_a: assert property (eoc && !repeat_reg && !wr_ctl |=> !run_reg && count_reg == 16'h0000)
        else $error("single pass did not stop at zero");
    cont_reload_a: assert property (eoc && repeat_reg && !do_restart |=> count_reg == $past(reload_reg))
        else $error("continuous mode did not reload");
    count_step_a: assert property (cnt_tick && !do_restart && !(eoc && repeat_reg)
        |=> count_reg == $past(count_reg) - 16'h0001)
        else $error("counter did not step by one");
    zero_wrap_a: assert property (cnt_tick && count_reg == 16'h0000 && !do_restart |=> count_reg == 16'hffff)
        else $error("counter did not wrap from zero");
    idle_hold_a: assert property (!run_reg && !do_restart |=> $stable(count_reg))
        else $error("stopped counter moved");
    flag_set_a: assert property (eoc |=> done_reg [*2] or (done_reg ##1 $past(ctl_rd)))
        else $error("done flag not set at end of count");
    flag_quiet_a: assert property (!eoc && !done_reg |=> !done_reg)
        else $error("done flag set without end of count");
    flag_hold_a: assert property (done_reg && !ctl_rd |=> done_reg)
        else $error("done flag dropped without control read");
    read_clear_a: assert property (ctl_rd && !eoc |=> !done_reg && !count_done_irq)
        else $error("control read did not clear flag");
    irq_gate_a: assert property (!ie_reg |-> !count_done_irq)
        else $error("request raised while disabled");
    // the fixed delay below fits the default five-edge pipeline only
    event_latency_a: assert property ($rose(sel_pin) ##1 sel_pin |-> ##3 evt_tick)
        else $error("event pin tick at wrong edge");
    osc_latency_a: assert property ($fell(slow_osc_out) |-> ##1 rtc_tick)
        else $error("oscillator tick at wrong edge");
    toggle_flip_a: assert property (eoc && tog_en_reg |=> toggle_reg != $past(toggle_reg))
        else $error("toggle output did not flip");

    // register side: control writes, restart load, reload low byte, coherent read
    ctl_write_a: assert property (wr_ctl |=> run_reg == $past(wr_data[`RLT_CTL_RUN]))
        else $error("control write not taken");
    restart_load_a: assert property (do_restart |=> count_reg == $past(reload_reg))
        else $error("restart did not load the reload value");
    reload_write_a: assert property (wr_pend_reg && wr_idx_reg == DATL_IDX
        |=> reload_reg[7:0] == $past(wr_data))
        else $error("reload low byte not written");
    high_latch_a: assert property (datl_rd |=> high_latch_reg == $past(count_reg[15:8]))
        else $error("high byte not latched on low read");

    // prescaler: one step per clock, back to zero after its terminal count;
    // together they give one tick every divide-ratio cycles
    prescale_step_a: assert property (run_reg && !do_restart && !pre_tick
        |=> prescale_reg == $past(prescale_reg) + 8'h01)
        else $error("prescaler did not advance");
    prescale_wrap_a: assert property (pre_tick || do_restart |=> prescale_reg == 8'h00)
        else $error("prescaler did not restart");

    // continuous mode keeps running; output moves only at an end, request rises at one
    cont_keep_a: assert property (eoc && repeat_reg && !wr_ctl |=> run_reg)
        else $error("continuous mode stopped by itself");
    toggle_hold_a: assert property (!eoc |=> $stable(toggle_reg))
        else $error("toggle output moved without an end");
    irq_rise_a: assert property (eoc && ie_reg && !wr_ctl |=> count_done_irq)
        else $error("request not raised at end of count");

    single_end_c: cover property (eoc && !repeat_reg);
    cont_end_c: cover property (eoc && repeat_reg ##[1:300] eoc);
    read_clear_c: cover property (ctl_rd && done_reg);
    event_count_c: cover property (evt_tick && run_reg && src_reg == RLT_SRC_PIN);
    wrap_c: cover property (cnt_tick && count_reg == 16'h0000);
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
`include "rlt_cfg.svh"
module tb_top;
    import rlt_pkg::*;
    typedef struct packed {
        rlt_div_t    dv;
        logic [15:0] rl;
        logic [15:0] cyc;
    } rlt_row_t;
    localparam logic [9:0] CTL0 = `RLT_CTL_IDX_BASE;
    localparam logic [9:0] CTL4 = CTL0 + 10'(4 * `RLT_IDX_STRIDE);
    localparam logic [9:0] CFG0 = `RLT_CFG_IDX_BASE;
    localparam logic [9:0] CFG4 = CFG0 + 10'h4;
    logic        sys_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic [1:0]  htrans  = 2'h0;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    logic [2:0]  go      = 3'h0;
    wire         event_pin_a, event_pin_b, slow_osc_out;
    wire  [1:0]  rdy, rsp, tog_a, oe_a, tog_b, oe_b, irq;
    wire  [31:0] rd [2];
    wire         hready  = &rdy;
    wire  [31:0] hrdata  = rd[0] | rd[1];
    int          num_errors = 0;
    int          checked    = 0;
    int          cycles     = 0;
    int          n;
    logic [7:0]  v;
    logic [7:0]  hi;
    rlt_row_t    rows [5] = '{'{RLT_DIV_4, 16'h1, 16'd4}, '{RLT_DIV_16, 16'h2, 16'd32},
        '{RLT_DIV_64, 16'h1, 16'd64}, '{RLT_DIV_256, 16'h1, 16'd256}, '{RLT_DIV_4, 16'h3, 16'd12}};

    // timer 0 has the pin and oscillator sources, timer 4 the toggle output
    for (genvar k = 0; k < 2; k++) begin : g_t
        rlt_timer #(.TIMER_INDEX(4 * k)) rlt_timer_i (
            .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
            .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready),
            .hwdata(hwdata), .hreadyout(rdy[k]), .hresp(rsp[k]), .hrdata(rd[k]),
            .event_pin_a(event_pin_a), .event_pin_b(event_pin_b),
            .slow_osc_out(slow_osc_out), .toggle_out_a(tog_a[k]),
            .toggle_out_a_oe(oe_a[k]), .toggle_out_b(tog_b[k]),
            .toggle_out_b_oe(oe_b[k]), .count_done_irq(irq[k]));
    end
    rlt_pin_model rlt_pin_model_i (.sys_clk(sys_clk), .reset(reset), .go(go),
        .event_pin_a(event_pin_a), .event_pin_b(event_pin_b), .slow_osc_out(slow_osc_out));

    // 100 MHz clock and a hang guard well above the expected run length
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end
        else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one single transfer; read data is taken at the end of the data phase
    task automatic bus(input logic [9:0] idx, input logic wr, input logic [7:0] wd, output logic [7:0] rv);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0, idx, 2'h0};
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge sys_clk); while (hready !== 1'b1);
        rv = hrdata[7:0];
        chk("hresp", rsp, 2'h0);
    endtask

    // reload bytes first, then control with restart set
    task automatic start(input int k, input rlt_div_t dv, input logic rep, input logic ie, input logic [15:0] rl);
        logic [9:0] c;
        c = CTL0 + 10'(k * 4 * `RLT_IDX_STRIDE);
        bus(c + 10'h1, 1'b1, rl[7:0], v);
        bus(c + 10'h2, 1'b1, rl[15:8], v);
        bus(c, 1'b1, {1'b0, ie, 1'b0, rep, dv, 2'b11}, v);
    endtask

    task automatic wait_irq(input int k, output int cnt);
        cnt = 0;
        do begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end while (irq[k] !== 1'b1 && cnt < 2000);
    endtask

    task automatic wait_tog(output int cnt);
        logic t;
        t = tog_a[1];
        cnt = 0;
        do begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end while (tog_a[1] === t && cnt < 2000);
    endtask

    task automatic pulse(input logic [2:0] sel);
        go <= sel;
        @(posedge sys_clk);
        go <= 3'h0;
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(CTL0, 1'b0, 8'h0, v);
        chk("ctl reset", v, 8'h00);
        chk("oe reset", oe_a[1], 1'b0);
        bus(10'h3ff, 1'b0, 8'h0, v);
        chk("unmapped", v, 8'h00);
        // single-pass time-outs over every divider code
        foreach (rows[i]) begin
            start(0, rows[i].dv, 1'b0, 1'b1, rows[i].rl);
            wait_irq(0, n);
            chk("timeout", n, rows[i].cyc);
            bus(CTL0, 1'b0, 8'h0, v);
            chk("ctl end", v & 8'hfd, {4'hc, rows[i].dv, 2'b00});
            chk("irq clear", irq[0], 1'b0);
            bus(CTL0 + 10'h1, 1'b0, 8'h0, v);
            chk("count end", v, 8'h00);
        end
        // polled flag with requests masked
        start(0, RLT_DIV_4, 1'b0, 1'b0, 16'h1);
        repeat (10) @(posedge sys_clk);
        chk("masked", irq[0], 1'b0);
        bus(CTL0, 1'b0, 8'h0, v);
        chk("poll", v & 8'hfd, 8'h80);
        bus(CTL0, 1'b0, 8'h0, v);
        chk("poll again", v & 8'hfd, 8'h00);
        // continuous mode with the toggle output
        bus(CFG4, 1'b1, 8'h04, v);
        #1;
        chk("oe on", oe_a[1], 1'b1);
        start(1, RLT_DIV_4, 1'b1, 1'b1, 16'h3);
        wait_tog(n);
        chk("first toggle", n, 12);
        chk("other outs", {tog_a[0], oe_a[0], tog_b, oe_b}, 6'h00);
        wait_tog(n);
        chk("half period", n, 12);
        chk("irq cont", irq[1], 1'b1);
        bus(CTL4, 1'b0, 8'h0, v);
        chk("ctl cont", v & 8'hfd, 8'hd1);
        bus(CTL4, 1'b1, 8'h50, v);
        wait_tog(n);
        chk("stopped", n, 2000);
        // event pins: the other pin is ignored, latency of five edges
        bus(CFG0, 1'b1, 8'h01, v);
        start(0, RLT_DIV_256, 1'b0, 1'b1, 16'h2);
        pulse(3'b010);
        repeat (6) @(posedge sys_clk);
        bus(CTL0 + 10'h1, 1'b0, 8'h0, v);
        chk("other pin", v, 8'h02);
        pulse(3'b001);
        repeat (6) @(posedge sys_clk);
        bus(CTL0 + 10'h1, 1'b0, 8'h0, v);
        chk("one event", v, 8'h01);
        pulse(3'b001);
        wait_irq(0, n);
        chk("pin latency", n, 5);
        bus(CTL0, 1'b0, 8'h0, v);
        // oscillator source counts on the second edge after its fall
        bus(CFG0, 1'b1, 8'h02, v);
        start(0, RLT_DIV_256, 1'b0, 1'b1, 16'h1);
        pulse(3'b100);
        wait_irq(0, n);
        chk("osc latency", n, 2);
        bus(CTL0, 1'b0, 8'h0, v);
        // no source selected: a running timer never moves; stop it before going back
        bus(CFG0, 1'b1, 8'h03, v);
        start(0, RLT_DIV_4, 1'b0, 1'b1, 16'h1);
        repeat (8) @(posedge sys_clk);
        chk("no source", irq[0], 1'b0);
        bus(CTL0, 1'b1, 8'h00, v);
        bus(CFG0, 1'b1, 8'h00, v);
        // high byte latched by the low read across a tick
        start(0, RLT_DIV_4, 1'b0, 1'b1, 16'h0100);
        bus(CTL0 + 10'h1, 1'b0, 8'h0, v);
        repeat (2) @(posedge sys_clk);
        bus(CTL0 + 10'h2, 1'b0, 8'h0, hi);
        chk("latched", {hi, v}, 16'h0100);
        // reload zero wraps and raises no flag
        start(0, RLT_DIV_4, 1'b0, 1'b1, 16'h0000);
        repeat (4) @(posedge sys_clk);
        bus(CTL0 + 10'h1, 1'b0, 8'h0, v);
        bus(CTL0 + 10'h2, 1'b0, 8'h0, hi);
        chk("wrap", {hi, v}, 16'hffff);
        chk("no flag", irq[0], 1'b0);
        // second reset in mid-run
        start(1, RLT_DIV_4, 1'b1, 1'b1, 16'h3);
        repeat (30) @(posedge sys_clk);
        reset <= 1'b1;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("reset outs", {tog_a[1], oe_a[1], irq[1]}, 3'b000);
        bus(CTL4 + 10'h1, 1'b1, 8'h55, v);
        bus(CTL4 + 10'h1, 1'b0, 8'h0, v);
        chk("shared addr", v, 8'h00);
        stop_test();
    end
endmodule
